/* File: verification/tb_rtca_alarm.sv */
// Self-checking bench for the alarm timer block
`timescale 1ns/1ps
module tb_rtca_alarm;
   import rtca_pkg::*;
   localparam int TK = 8;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic osc_amp_ok = 1'b0;
   rtca_axil_req_t req = '0;
   rtca_axil_rsp_t rsp;
   logic rst_o, wake_o, irq_o, bias_o, agc_o, red_o;
   int fails = 0;
   int n_tests = 0;
   int seed = 32'h0100;
   logic [31:0] d, v;
   logic [1:0] r;
   int hi, per;
   int cyc = 0;
   int t0;
   rtca_alarm #(.TICK_CYCLES(TK)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
      .axi_req(req), .axi_rsp(rsp), .osc_amp_ok(osc_amp_ok), .alarm_reset_req(rst_o),
      .alarm_wake_req(wake_o), .alarm_irq_req(irq_o), .osc_bias_double(bias_o),
      .osc_agc_enable(agc_o), .osc_drive_reduce(red_o));
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tmo();
      fails++;
      $display("[ERR] wait expired");
      end_of_test();
   endtask
   // Handshake flags are sampled at the falling edge, where registered outputs are settled
   task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rr);
      logic aw, w, b;
      b = 1'b0;
      @(posedge core_clk);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= dd;
      req.wstrb <= 4'hf;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      for (int i = 0; i < 100 && !b; i++) begin
         @(negedge core_clk);
         aw = req.awvalid && rsp.awready === 1'b1;
         w = req.wvalid && rsp.wready === 1'b1;
         b = rsp.bvalid === 1'b1;
         rr = rsp.bresp;
         @(posedge core_clk);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
         if (b) req.bready <= 1'b0;
      end
      if (!b) tmo();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rr);
      logic ar, rv;
      rv = 1'b0;
      @(posedge core_clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      for (int i = 0; i < 100 && !rv; i++) begin
         @(negedge core_clk);
         ar = req.arvalid && rsp.arready === 1'b1;
         rv = rsp.rvalid === 1'b1;
         dd = rsp.rdata;
         rr = rsp.rresp;
         @(posedge core_clk);
         if (ar) req.arvalid <= 1'b0;
         if (rv) req.rready <= 1'b0;
      end
      if (!rv) tmo();
   endtask
   // Waits for a rise of the interrupt route, then counts its high time and the period
   task automatic meas(output int h, output int p);
      int i;
      for (i = 0; i < 2000 && irq_o !== 1'b1; i++) @(negedge core_clk);
      if (i == 2000) tmo();
      chk("route_reset", rst_o, 1'b1);
      chk("route_wake", wake_o, 1'b1);
      h = 0;
      for (p = 1; p < 2000; p++) begin
         if (irq_o === 1'b1) h++;
         @(negedge core_clk);
         if (irq_o === 1'b1 && h != p) break;
      end
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(OFS_CTRL, d, r);
      chk("ctrl_rst", d, 32'h4);
      rd(OFS_OSC, d, r);
      chk("osc_rst", d, 32'h0);
      rd(OFS_ALARM, d, r);
      chk("alarm_rst", d, 32'h0);
      wr(8'h14, 32'h1, r);
      chk("wr_unmapped", r, RESP_SLVERR);
      rd(8'h14, d, r);
      chk("rd_unmapped", d, 32'h0);
      chk("rd_unmapped_resp", r, RESP_SLVERR);
      $display("test reset_map done");
      v = ($random(seed) & 32'h7) + 32'h2;
      wr(OFS_CTRL, 32'h0, r);
      wr(OFS_TIMER, 32'h0, r);
      wr(OFS_ALARM, v, r);
      wr(OFS_CTRL, 32'h3f, r);
      meas(hi, per);
      chk("flag_len", hi, TK);
      chk("period", per, (v + 1) * TK);
      $display("test auto_reset done");
      for (int i = 0; i < 2000 && irq_o !== 1'b1; i++) @(negedge core_clk);
      if (irq_o !== 1'b1) tmo();
      wr(OFS_CTRL, 32'h3e, r);
      @(negedge core_clk);
      chk("flag_clear", irq_o, 1'b0);
      rd(OFS_STATUS, d, r);
      chk("status", d, 32'h2);
      $display("test disable_clear done");
      wr(OFS_CTRL, 32'h0, r);
      // Differs from the count only in the top bit, so a narrow compare would fire
      wr(OFS_ALARM, 32'h8000_0005, r);
      wr(OFS_TIMER, 32'h0, r);
      wr(OFS_CTRL, 32'h3d, r);
      hi = 0;
      repeat (20 * TK) begin
         @(negedge core_clk);
         if (irq_o !== 1'b0) hi++;
      end
      chk("no_partial_match", hi, 0);
      wr(OFS_CTRL, 32'h4, r);
      wr(OFS_TIMER, 32'hffff_fffe, r);
      repeat (4 * TK) @(negedge core_clk);
      rd(OFS_TIMER, d, r);
      chk("wrap", d < 32'h8, 1'b1);
      $display("test match_wrap done");
      v = ($random(seed) & 32'h7) + 32'h3;
      d = 32'hffff_fffe;
      wr(OFS_CTRL, 32'h0, r);
      wr(OFS_TIMER, 32'hffff_fffc, r);
      wr(OFS_ALARM, d, r);
      wr(OFS_CTRL, 32'h3d, r);
      for (int i = 0; i < 2000 && irq_o !== 1'b1; i++) @(negedge core_clk);
      if (irq_o !== 1'b1) tmo();
      t0 = cyc;
      wr(OFS_CTRL, 32'h3c, r);
      wr(OFS_ALARM, d + v, r);
      wr(OFS_CTRL, 32'h3d, r);
      for (int i = 0; i < 2000 && irq_o !== 1'b1; i++) @(negedge core_clk);
      if (irq_o !== 1'b1) tmo();
      chk("rebase_period", cyc - t0, v * TK);
      $display("test perpetual done");
      for (int k = 0; k < 6; k++) begin
         v = $random(seed);
         if (k < 2) begin
            v[1:0] = 2'b11;
            v[8] = (k == 0);
         end
         v[1] = v[1] & v[0];
         osc_amp_ok <= v[8];
         wr(OFS_OSC, v, r);
         repeat (5) @(negedge core_clk);
         chk("bias", bias_o, v[5]);
         chk("agc", agc_o, v[1] & v[0]);
         chk("drive", red_o, v[1] & v[0] & v[8]);
         rd(OFS_OSC, d, r);
         chk("osc_rd", d, (v & 32'h23) | (32'(v[8]) << 7));
      end
      $display("test oscillator done");
      end_of_test();
   end
endmodule

/* File: verilog/rtca_alarm.sv */
// Alarm timer with match flag, auto-reset, event routing and oscillator controls
// Notes on behaviour
// - Alarm fires only on exact 32-bit equality
// - Auto-reset zeroes timer on the tick that raises the alarm
// - Alarm may drive reset, wake or interrupt
// - Writing enable low clears the flag
// - Re-enable without new match waits full wrap
// - Flag lasts at most one oscillator tick unless auto-reset runs with alarm zero
// - Without auto-reset the timer wraps freely
// - Bias doubling bit drives oscillator bias high
// - Gain control reduces drive once amplitude suffices
`timescale 1ns/1ps
module rtca_alarm #(
   parameter int unsigned TICK_CYCLES = rtca_pkg::RTC_TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire rtca_pkg::rtca_axil_req_t axi_req,
   output rtca_pkg::rtca_axil_rsp_t axi_rsp,
   input wire logic osc_amp_ok,
   output logic alarm_reset_req,
   output logic alarm_wake_req,
   output logic alarm_irq_req,
   output logic osc_bias_double,
   output logic osc_agc_enable,
   output logic osc_drive_reduce
);
   import rtca_pkg::*;

   logic [31:0] div_q, div_d;
   logic tick_q, tick_d;
   logic amp_meta_q, amp_sync_q;
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   rtca_axil_rsp_t rsp_q, rsp_d;
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [7:0] osc_q, osc_d;
   logic [31:0] alarm_q, alarm_d, timer_q, timer_d;
   logic flag_q, flag_d, seen_q, seen_d;
   logic rst_req_q, rst_req_d, wake_req_q, wake_req_d, irq_req_q, irq_req_d;
   logic agc_q, agc_d, bias_q, bias_d, reduce_q, reduce_d;
   logic wr_fire, match_w, fire_w;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Oscillator tick enable from the core clock
   always_comb begin
      tick_d = (div_q == 32'(TICK_CYCLES - 1));
      div_d = tick_d ? 32'h0 : div_q + 32'h1;
   end

   // Amplitude detector comes from the analog side
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         amp_meta_q <= 1'b0;
         amp_sync_q <= 1'b0;
      end else begin
         amp_meta_q <= osc_amp_ok;
         amp_sync_q <= amp_meta_q;
      end
   end

   assign wr_fire = aw_hold_q && w_hold_q && !rsp_q.bvalid;
   assign match_w = (timer_q == alarm_q);
   assign fire_w = tick_q && ctrl_q[CTRL_RUN] && ctrl_q[CTRL_ALARM_EN] && match_w;

   // Bus slave: address and data taken in either order, one response each
   always_comb begin
      aw_hold_d = aw_hold_q;
      aw_addr_d = aw_addr_q;
      w_hold_d = w_hold_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      rsp_d = rsp_q;
      if (axi_req.awvalid && rsp_q.awready) begin
         aw_hold_d = 1'b1;
         aw_addr_d = axi_req.awaddr;
      end
      if (axi_req.wvalid && rsp_q.wready) begin
         w_hold_d = 1'b1;
         w_data_d = axi_req.wdata;
         w_strb_d = axi_req.wstrb;
      end
      if (rsp_q.bvalid && axi_req.bready) begin
         rsp_d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
         rsp_d.bvalid = 1'b1;
         case (aw_addr_q)
            OFS_CTRL, OFS_ALARM, OFS_TIMER, OFS_OSC, OFS_STATUS: rsp_d.bresp = RESP_OKAY;
            default: rsp_d.bresp = RESP_SLVERR;
         endcase
      end
      rsp_d.awready = !aw_hold_d;
      rsp_d.wready = !w_hold_d;
      if (rsp_q.rvalid && axi_req.rready) begin
         rsp_d.rvalid = 1'b0;
      end
      if (axi_req.arvalid && rsp_q.arready) begin
         rsp_d.rvalid = 1'b1;
         rsp_d.rresp = RESP_OKAY;
         case (axi_req.araddr)
            OFS_CTRL: rsp_d.rdata = {26'h0, ctrl_q};
            OFS_ALARM: rsp_d.rdata = alarm_q;
            OFS_TIMER: rsp_d.rdata = timer_q;
            OFS_OSC: rsp_d.rdata = {24'h0, amp_sync_q, osc_q[6:0]};
            OFS_STATUS: rsp_d.rdata = {30'h0, seen_q, flag_q};
            default: begin
               rsp_d.rdata = 32'h0;
               rsp_d.rresp = RESP_SLVERR;
            end
         endcase
      end
      rsp_d.arready = !rsp_d.rvalid;
   end

   // Timer, alarm and oscillator state
   always_comb begin
      ctrl_d = ctrl_q;
      alarm_d = alarm_q;
      osc_d = osc_q;
      timer_d = timer_q;
      flag_d = flag_q;
      seen_d = seen_q;
      if (tick_q) begin
         flag_d = 1'b0;
         if (ctrl_q[CTRL_RUN]) begin
            if (fire_w) begin
               flag_d = 1'b1;
               timer_d = ctrl_q[CTRL_AUTO_RESET] ? 32'h0 : timer_q + 32'h1;
            end else begin
               // Timer moves past the match, so re-enabling waits a full wrap
               timer_d = timer_q + 32'h1;
            end
         end
      end
      if (wr_fire) begin
         case (aw_addr_q)
            OFS_CTRL: begin
               ctrl_d = CTRL_W'(merge({26'h0, ctrl_q}, w_data_q, w_strb_q));
               // Disable wins over a match in the same cycle, so no stale event leaks out
               if (!ctrl_d[CTRL_ALARM_EN]) begin
                  flag_d = 1'b0;
               end
            end
            OFS_ALARM: alarm_d = merge(alarm_q, w_data_q, w_strb_q);
            OFS_TIMER: timer_d = merge(timer_q, w_data_q, w_strb_q);
            OFS_OSC: begin
               if (w_strb_q[0]) begin
                  osc_d = w_data_q[7:0] & OSC_WR_MASK;
               end
            end
            OFS_STATUS: begin
               if (w_strb_q[0] && w_data_q[STAT_SEEN]) begin
                  seen_d = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Sticky copy lets slow software see a one-tick flag; set beats clear
      if (flag_d) begin
         seen_d = 1'b1;
      end
      rst_req_d = flag_d && ctrl_d[CTRL_ROUTE_RESET];
      wake_req_d = flag_d && ctrl_d[CTRL_ROUTE_WAKE];
      irq_req_d = flag_d && ctrl_d[CTRL_ROUTE_IRQ];
      bias_d = osc_d[OSC_BIAS_DOUBLE];
      // Gain control only acts in crystal mode, guarding a careless setting
      agc_d = osc_d[OSC_AGC_EN] && osc_d[OSC_XTAL_MODE];
      reduce_d = agc_d && amp_sync_q;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         div_q <= 32'h0;
         tick_q <= 1'b0;
         aw_hold_q <= 1'b0;
         aw_addr_q <= 8'h0;
         w_hold_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         rsp_q <= '0;
         ctrl_q <= CTRL_RESET_VAL;
         alarm_q <= ALARM_RESET_VAL;
         osc_q <= OSC_RESET_VAL;
         timer_q <= TIMER_RESET_VAL;
         flag_q <= 1'b0;
         seen_q <= 1'b0;
         rst_req_q <= 1'b0;
         wake_req_q <= 1'b0;
         irq_req_q <= 1'b0;
         bias_q <= 1'b0;
         agc_q <= 1'b0;
         reduce_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
         aw_hold_q <= aw_hold_d;
         aw_addr_q <= aw_addr_d;
         w_hold_q <= w_hold_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         rsp_q <= rsp_d;
         ctrl_q <= ctrl_d;
         alarm_q <= alarm_d;
         osc_q <= osc_d;
         timer_q <= timer_d;
         flag_q <= flag_d;
         seen_q <= seen_d;
         rst_req_q <= rst_req_d;
         wake_req_q <= wake_req_d;
         irq_req_q <= irq_req_d;
         bias_q <= bias_d;
         agc_q <= agc_d;
         reduce_q <= reduce_d;
      end
   end

   assign axi_rsp = rsp_q;
   assign alarm_reset_req = rst_req_q;
   assign alarm_wake_req = wake_req_q;
   assign alarm_irq_req = irq_req_q;
   assign osc_bias_double = bias_q;
   assign osc_agc_enable = agc_q;
   assign osc_drive_reduce = reduce_q;

   // Checks
   logic [31:0] flag_age_q;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         flag_age_q <= 32'h0;
      end else begin
         flag_age_q <= flag_q ? flag_age_q + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_fire_quiet;
      fire_w && !wr_fire;
   endsequence
   sequence s_step_quiet;
      tick_q && ctrl_q[CTRL_RUN] && !fire_w && !wr_fire;
   endsequence

   AST_MATCH_SETS_FLAG: assert property (s_fire_quiet |=> flag_q)
      else $error("match did not raise alarm flag");
   AST_FLAG_ONLY_ON_MATCH: assert property ($rose(flag_q) |-> $past(fire_w))
      else $error("alarm flag rose without a match");
   AST_AUTO_RESET: assert property (s_fire_quiet and ctrl_q[CTRL_AUTO_RESET] |=>
      timer_q == 32'h0)
      else $error("auto-reset did not clear timer");
   AST_ROUTE: assert property ((alarm_irq_req == (flag_q && ctrl_q[CTRL_ROUTE_IRQ])) &&
      (alarm_reset_req == (flag_q && ctrl_q[CTRL_ROUTE_RESET])))
      else $error("alarm routing mismatch");
   AST_ROUTE_WAKE: assert property (alarm_wake_req == (flag_q && ctrl_q[CTRL_ROUTE_WAKE]))
      else $error("wake routing mismatch");
   AST_DISABLE_CLEARS: assert property (wr_fire && aw_addr_q == OFS_CTRL && w_strb_q[0] &&
      !w_data_q[CTRL_ALARM_EN] |=> !flag_q)
      else $error("disabling alarm left flag set");
   AST_FLAG_ONE_TICK: assert property (flag_age_q <= TICK_CYCLES)
      else $error("alarm flag held beyond one tick");
   AST_COUNT_STEP: assert property (s_step_quiet |=> timer_q == $past(timer_q) + 32'h1)
      else $error("timer did not advance by one");
   AST_WRAP: assert property (s_step_quiet and timer_q == 32'hffff_ffff |=> timer_q == 32'h0)
      else $error("timer did not wrap to zero");
   AST_BIAS: assert property (osc_bias_double == osc_q[OSC_BIAS_DOUBLE])
      else $error("bias output differs from control bit");
   AST_AGC_REDUCE: assert property (osc_drive_reduce |-> osc_agc_enable && $past(amp_sync_q))
      else $error("drive reduced without gain control and amplitude");
endmodule

/* File: verilog/rtca_pkg.sv */
// Constants, register map and bus carriers for the alarm timer block
package rtca_pkg;
   // Clock rates
   localparam int unsigned CORE_CLK_HZ = 200_000_000;
   localparam int unsigned RTC_OSC_HZ = 32_768;
   // Core cycles per oscillator cycle, rounded down
   localparam int unsigned RTC_TICK_CYCLES = CORE_CLK_HZ / RTC_OSC_HZ;

   localparam int ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ALARM = 8'h04;
   localparam logic [7:0] OFS_TIMER = 8'h08;
   localparam logic [7:0] OFS_OSC = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // Control register fields
   localparam int CTRL_ALARM_EN = 0;
   localparam int CTRL_AUTO_RESET = 1;
   localparam int CTRL_RUN = 2;
   localparam int CTRL_ROUTE_RESET = 3;
   localparam int CTRL_ROUTE_WAKE = 4;
   localparam int CTRL_ROUTE_IRQ = 5;
   localparam int CTRL_W = 6;
   localparam logic [5:0] CTRL_RESET_VAL = 6'h04;

   // Oscillator control fields
   localparam int OSC_XTAL_MODE = 0;
   localparam int OSC_AGC_EN = 1;
   localparam int OSC_BIAS_DOUBLE = 5;
   localparam int OSC_AMP_OK = 7;
   localparam logic [7:0] OSC_RESET_VAL = 8'h00;
   localparam logic [7:0] OSC_WR_MASK = 8'h23;

   // Status fields
   localparam int STAT_FLAG = 0;
   localparam int STAT_SEEN = 1;

   localparam logic [31:0] ALARM_RESET_VAL = 32'h0000_0000;
   localparam logic [31:0] TIMER_RESET_VAL = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } rtca_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } rtca_axil_rsp_t;
endpackage
